//--- logic/crtt_pkg.sv
// constants for the crt horizontal and vertical timing register block
package crtt_pkg;
    // port select: index port or data port
    localparam logic PORT_INDEX = 1'b0;
    localparam logic PORT_DATA = 1'b1;
    localparam int INDEX_W = 5;
    // register indexes
    localparam logic [4:0] IDX_HBLANK_END = 5'h03;
    localparam logic [4:0] IDX_HRETRACE_START = 5'h04;
    localparam logic [4:0] IDX_HRETRACE_END = 5'h05;
    localparam logic [4:0] IDX_VERTICAL_TOTAL_LOW = 5'h06;
    localparam logic [4:0] IDX_VERTICAL_HIGH_BITS = 5'h07;
    localparam logic [4:0] IDX_ROW_SCAN_PRESET = 5'h08;
    localparam logic [4:0] IDX_CHAR_ROW_HEIGHT = 5'h09;
    localparam logic [4:0] IDX_CURSOR_FIRST_ROW = 5'h0a;
    // field positions
    localparam int SKEW_LSB = 5;
    localparam int SKEW_MSB = 6;
    localparam int LOW5_MSB = 4;
    localparam int TOP_BIT = 7;
    localparam int DOUBLE_SCAN_BIT = 7;
    localparam int SPLIT_B9_BIT = 6;
    localparam int VBLANK_B9_BIT = 5;
    localparam int CURSOR_OFF_BIT = 5;
    localparam int OV_VSYNC_B9 = 7;
    localparam int OV_VACTIVE_B9 = 6;
    localparam int OV_FRAME_B9 = 5;
    localparam int OV_SPLIT_B8 = 4;
    localparam int OV_VBLANK_B8 = 3;
    localparam int OV_VSYNC_B8 = 2;
    localparam int OV_VACTIVE_B8 = 1;
    localparam int OV_FRAME_B8 = 0;
    // write masks for bits that hold state; others read zero; hblank end top bit reads one
    localparam logic [7:0] MASK_PRESET = 8'h7f;
    localparam logic [7:0] MASK_CURSOR = 8'h3f;
    localparam logic [7:0] FORCE_HBLANK_TOP = 8'h80;
    // reset value for every data register and the index
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [4:0] INDEX_RESET = 5'h00;
    localparam int SKEW_DEPTH = 4;
endpackage

//--- logic/crtt_timing.sv
// crt horizontal/vertical timing registers with their timing logic
//
// Contract
// - display-enable out is delayed 0..3 character clocks by its skew field
// - hblank ends when 6-bit end value matches horizontal count low bits
// - hsync starts when character count equals the 8-bit retrace start
// - retrace delay field skews hsync out by 0..3 character clocks
// - internal timing events come from the falling edge of hsync
// - hsync ends when five-bit stop field matches low count bits
// - frame line total is ten bits, lines per frame minus two
// - overflow register supplies bit 8 of vertical values, bit 9 of frame, vsync and vactive
// - byte panning field drives panning; extended graphics forces zero
// - row scan counter loads first row scan after each vertical retrace
// - row scan counter increments per hsync, clears after maximum row
// - start address is captured at start of vertical retrace
// - double scan halves the row scan counter clock
// - row height bit 6 is split line bit 9, bit 5 vblank bit 9
// - row height field gives lines per character row minus one
// - cursor disable bit suppresses the cursor entirely
// - cursor first line field gives the first cursor row
// - no cursor when first line exceeds last line
// - blanking end bit 7 written one by software; reads back one
// - hblank starts when character count equals blanking start
// - index port selects register; data port then reads or writes it
`timescale 1ns/10ps
module crtt_timing #(
    parameter int CNT_W = 8,
    parameter int ROW_W = 5,
    parameter int VPOS_W = 10,
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic io_sel,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic char_tick,
    input wire logic [CNT_W-1:0] hcount,
    input wire logic [CNT_W-1:0] hblank_begin,
    input wire logic display_enable_raw,
    input wire logic vretrace,
    input wire logic ext_graphics,
    input wire logic [ROW_W-1:0] cursor_last_line,
    input wire logic [ADDR_W-1:0] start_addr,
    output logic display_enable,
    output logic hblank,
    output logic hsync,
    output logic [ROW_W-1:0] row_scan,
    output logic cursor_row,
    output logic [1:0] byte_pan,
    output logic [ADDR_W-1:0] start_addr_latched,
    output logic [VPOS_W-1:0] frame_lines,
    output logic [VPOS_W-1:0] vsync_start_hi,
    output logic [VPOS_W-1:0] vactive_end_hi,
    output logic [VPOS_W-1:0] split_line_hi,
    output logic [VPOS_W-1:0] vblank_start_hi
);
    logic [crtt_pkg::INDEX_W-1:0] index;
    logic [7:0] hblank_end;
    logic [7:0] hretrace_start;
    logic [7:0] hretrace_end;
    logic [7:0] vertical_total_low;
    logic [7:0] vertical_high_bits;
    logic [7:0] row_scan_preset;
    logic [7:0] char_row_height;
    logic [7:0] cursor_first_row;
    logic hsync_raw;
    logic hblank_raw;
    logic [crtt_pkg::SKEW_DEPTH-1:0] de_pipe;
    logic [crtt_pkg::SKEW_DEPTH-1:0] hs_pipe;
    logic hsync_prev;
    logic vretrace_prev;
    logic reload_pending;
    logic half_phase;
    logic [7:0] next_rdata;

    // field views
    logic [1:0] de_skew;
    logic [1:0] hsync_delay;
    logic [5:0] hblank_stop;
    logic [ROW_W-1:0] hsync_stop;
    logic [ROW_W-1:0] first_row_scan;
    logic [ROW_W-1:0] row_height;
    logic [ROW_W-1:0] cursor_first_line;
    logic double_scan;
    logic cursor_disable;
    logic hsync_fall;
    logic vretrace_rise;
    logic vretrace_fall;
    logic cursor_now;

    assign de_skew = hblank_end[crtt_pkg::SKEW_MSB:crtt_pkg::SKEW_LSB];
    assign hsync_delay = hretrace_end[crtt_pkg::SKEW_MSB:crtt_pkg::SKEW_LSB];
    assign hblank_stop = {hretrace_end[crtt_pkg::TOP_BIT],
        hblank_end[crtt_pkg::LOW5_MSB:0]};
    assign hsync_stop = hretrace_end[crtt_pkg::LOW5_MSB:0];
    assign first_row_scan = row_scan_preset[crtt_pkg::LOW5_MSB:0];
    assign row_height = char_row_height[crtt_pkg::LOW5_MSB:0];
    assign cursor_first_line = cursor_first_row[crtt_pkg::LOW5_MSB:0];
    assign double_scan = char_row_height[crtt_pkg::DOUBLE_SCAN_BIT];
    assign cursor_disable = cursor_first_row[crtt_pkg::CURSOR_OFF_BIT];
    // hsync output is the skewed one; events follow its trailing edge
    assign hsync_fall = hsync_prev & ~hsync;
    assign vretrace_rise = vretrace & ~vretrace_prev;
    assign vretrace_fall = vretrace_prev & ~vretrace;

    // index register, five bits wide
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            index <= crtt_pkg::INDEX_RESET;
        end else if (io_wr && io_sel == crtt_pkg::PORT_INDEX) begin
            index <= io_wdata[crtt_pkg::INDEX_W-1:0];
        end
    end

    // data register writes through the data port
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hblank_end <= crtt_pkg::REG_RESET;
            hretrace_start <= crtt_pkg::REG_RESET;
            hretrace_end <= crtt_pkg::REG_RESET;
            vertical_total_low <= crtt_pkg::REG_RESET;
            vertical_high_bits <= crtt_pkg::REG_RESET;
            row_scan_preset <= crtt_pkg::REG_RESET;
            char_row_height <= crtt_pkg::REG_RESET;
            cursor_first_row <= crtt_pkg::REG_RESET;
        end else if (io_wr && io_sel == crtt_pkg::PORT_DATA) begin
            case (index)
                crtt_pkg::IDX_HBLANK_END: begin
                    hblank_end <= io_wdata;
                end
                crtt_pkg::IDX_HRETRACE_START: begin
                    hretrace_start <= io_wdata;
                end
                crtt_pkg::IDX_HRETRACE_END: begin
                    hretrace_end <= io_wdata;
                end
                crtt_pkg::IDX_VERTICAL_TOTAL_LOW: begin
                    vertical_total_low <= io_wdata;
                end
                crtt_pkg::IDX_VERTICAL_HIGH_BITS: begin
                    vertical_high_bits <= io_wdata;
                end
                crtt_pkg::IDX_ROW_SCAN_PRESET: begin
                    row_scan_preset <= io_wdata & crtt_pkg::MASK_PRESET;
                end
                crtt_pkg::IDX_CHAR_ROW_HEIGHT: begin
                    char_row_height <= io_wdata;
                end
                crtt_pkg::IDX_CURSOR_FIRST_ROW: begin
                    cursor_first_row <= io_wdata & crtt_pkg::MASK_CURSOR;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped indexes read zero
    always_comb begin
        next_rdata = crtt_pkg::REG_RESET;
        if (io_sel == crtt_pkg::PORT_INDEX) begin
            next_rdata = {3'h0, index};
        end else begin
            case (index)
                crtt_pkg::IDX_HBLANK_END: begin
                    // top bit is undefined; a one is returned
                    next_rdata = hblank_end | crtt_pkg::FORCE_HBLANK_TOP;
                end
                crtt_pkg::IDX_HRETRACE_START: begin
                    next_rdata = hretrace_start;
                end
                crtt_pkg::IDX_HRETRACE_END: begin
                    next_rdata = hretrace_end;
                end
                crtt_pkg::IDX_VERTICAL_TOTAL_LOW: begin
                    next_rdata = vertical_total_low;
                end
                crtt_pkg::IDX_VERTICAL_HIGH_BITS: begin
                    next_rdata = vertical_high_bits;
                end
                crtt_pkg::IDX_ROW_SCAN_PRESET: begin
                    next_rdata = row_scan_preset;
                end
                crtt_pkg::IDX_CHAR_ROW_HEIGHT: begin
                    next_rdata = char_row_height;
                end
                crtt_pkg::IDX_CURSOR_FIRST_ROW: begin
                    next_rdata = cursor_first_row;
                end
                default: begin
                    next_rdata = crtt_pkg::REG_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            io_rdata <= crtt_pkg::REG_RESET;
        end else if (io_rd) begin
            io_rdata <= next_rdata;
        end
    end

    // undelayed hsync and hblank from the character count comparators
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hsync_raw <= 1'b0;
        end else if (char_tick) begin
            if (hcount == hretrace_start) begin
                hsync_raw <= 1'b1;
            end else if (hcount[ROW_W-1:0] == hsync_stop) begin
                hsync_raw <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hblank_raw <= 1'b0;
        end else if (char_tick) begin
            if (hcount == hblank_begin) begin
                hblank_raw <= 1'b1;
            end else if (hcount[5:0] == hblank_stop) begin
                hblank_raw <= 1'b0;
            end
        end
    end

    // skew pipes advance once per character clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            de_pipe <= '0;
            hs_pipe <= '0;
        end else if (char_tick) begin
            de_pipe <= {de_pipe[crtt_pkg::SKEW_DEPTH-2:0], display_enable_raw};
            hs_pipe <= {hs_pipe[crtt_pkg::SKEW_DEPTH-2:0], hsync_raw};
        end
    end

    // tap 0 is the undelayed value, tap n is n character clocks late
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            display_enable <= 1'b0;
            hsync <= 1'b0;
            hblank <= 1'b0;
        end else begin
            display_enable <= (de_skew == 2'd0) ? display_enable_raw :
                de_pipe[de_skew - 2'd1];
            hsync <= (hsync_delay == 2'd0) ? hsync_raw :
                hs_pipe[hsync_delay - 2'd1];
            hblank <= hblank_raw;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hsync_prev <= 1'b0;
            vretrace_prev <= 1'b0;
        end else begin
            hsync_prev <= hsync;
            vretrace_prev <= vretrace;
        end
    end

    // start address is caught as vertical retrace begins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_addr_latched <= '0;
        end else if (vretrace_rise) begin
            start_addr_latched <= start_addr;
        end
    end

    // preset is applied at the first line after vertical retrace ends
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reload_pending <= 1'b0;
        end else if (vretrace_fall) begin
            reload_pending <= 1'b1;
        end else if (hsync_fall) begin
            reload_pending <= 1'b0;
        end
    end

    // double scan: only every other line advances the counter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            half_phase <= 1'b0;
        end else if (hsync_fall && reload_pending) begin
            half_phase <= 1'b0;
        end else if (hsync_fall) begin
            half_phase <= ~half_phase & double_scan;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            row_scan <= '0;
        end else if (hsync_fall) begin
            if (reload_pending) begin
                row_scan <= first_row_scan;
            end else if (double_scan && !half_phase) begin
                row_scan <= row_scan;
            end else if (row_scan >= row_height) begin
                // clears, does not reload the preset
                row_scan <= '0;
            end else begin
                row_scan <= row_scan + 1'b1;
            end
        end
    end

    // cursor rows are compared as stored codes on both ends
    assign cursor_now = !cursor_disable
        && (cursor_first_line <= cursor_last_line)
        && (row_scan >= cursor_first_line)
        && (row_scan <= cursor_last_line);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cursor_row <= 1'b0;
        end else begin
            cursor_row <= cursor_now;
        end
    end

    // extended graphics mode ignores the panning field
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            byte_pan <= 2'd0;
        end else if (ext_graphics) begin
            byte_pan <= 2'd0;
        end else begin
            byte_pan <= row_scan_preset[crtt_pkg::SKEW_MSB:crtt_pkg::SKEW_LSB];
        end
    end

    // assembled vertical values, high bits from the overflow and row height registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frame_lines <= '0;
            vsync_start_hi <= '0;
            vactive_end_hi <= '0;
            split_line_hi <= '0;
            vblank_start_hi <= '0;
        end else begin
            frame_lines <= {vertical_high_bits[crtt_pkg::OV_FRAME_B9],
                vertical_high_bits[crtt_pkg::OV_FRAME_B8],
                vertical_total_low};
            vsync_start_hi <= {vertical_high_bits[crtt_pkg::OV_VSYNC_B9],
                vertical_high_bits[crtt_pkg::OV_VSYNC_B8], 8'h00};
            vactive_end_hi <= {vertical_high_bits[crtt_pkg::OV_VACTIVE_B9],
                vertical_high_bits[crtt_pkg::OV_VACTIVE_B8], 8'h00};
            split_line_hi <= {char_row_height[crtt_pkg::SPLIT_B9_BIT],
                vertical_high_bits[crtt_pkg::OV_SPLIT_B8],
                8'h00};
            vblank_start_hi <= {char_row_height[crtt_pkg::VBLANK_B9_BIT],
                vertical_high_bits[crtt_pkg::OV_VBLANK_B8],
                8'h00};
        end
    end
endmodule

//--- testbench/crtt_timing_assertions.sv
// checker for the crt timing register block ports
`timescale 1ns/10ps
module crtt_timing_assertions #(
    parameter int CNT_W = 8,
    parameter int VPOS_W = 10
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic io_sel,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input logic [7:0] io_rdata,
    input wire logic char_tick,
    input wire logic [CNT_W-1:0] hcount,
    input wire logic ext_graphics,
    input wire logic vretrace,
    input wire logic [15:0] start_addr,
    input logic [15:0] start_addr_latched,
    input logic hsync,
    input logic [4:0] row_scan,
    input logic cursor_row,
    input logic [1:0] byte_pan,
    input logic [VPOS_W-1:0] frame_lines,
    input logic [VPOS_W-1:0] vsync_start_hi,
    input logic [VPOS_W-1:0] vactive_end_hi,
    input logic [VPOS_W-1:0] split_line_hi,
    input logic [VPOS_W-1:0] vblank_start_hi
);
    // shadow copy of the registers, rebuilt from the port traffic
    logic [4:0] idx;
    logic [7:0] sh [3:10];
    logic [1:0] quiet;
    logic q;
    assign q = quiet == 2'h3;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            idx <= 5'h00;
            quiet <= 2'h0;
            for (int i = 3; i <= 10; i++) sh[i] <= 8'h00;
        end else begin
            quiet <= io_wr ? 2'h0 : (q ? quiet : quiet + 2'h1);
            if (io_wr && !io_sel) idx <= io_wdata[4:0];
            if (io_wr && io_sel && idx >= 5'h03 && idx <= 5'h0a)
                sh[idx] <= io_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence tick_at_start;
        char_tick && hcount == sh[4] && sh[5][6:5] == 2'h0 && q;
    endsequence
    sequence sync_up;
        ##2 hsync;
    endsequence
    rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    pan_zero_a: assert property (ext_graphics |=> byte_pan == 2'h0)
        else $error("byte pan not zero in extended graphics");
    addr_catch_a: assert property ($rose(vretrace) |=>
        start_addr_latched == $past(start_addr))
        else $error("start address not captured");
    frame_total_a: assert property (q |->
        frame_lines == {sh[7][5], sh[7][0], sh[6]})
        else $error("frame line total wrong");
    vert_high_a: assert property (q |->
        vsync_start_hi == {sh[7][7], sh[7][2], 8'h00} &&
        vactive_end_hi == {sh[7][6], sh[7][1], 8'h00})
        else $error("vertical high bits wrong");
    row_high_a: assert property (q |->
        split_line_hi == {sh[9][6], sh[7][4], 8'h00} &&
        vblank_start_hi == {sh[9][5], sh[7][3], 8'h00})
        else $error("split or blank high bits wrong");
    sync_start_a: assert property (tick_at_start |-> sync_up)
        else $error("retrace did not start on time");
    cursor_off_a: assert property (q && sh[10][5] |=> !cursor_row)
        else $error("cursor shown while disabled");
    row_step_a: assert property ($changed(row_scan) |->
        $past(hsync, 2) && !$past(hsync))
        else $error("row scan moved off a retrace fall");
endmodule

//--- testbench/crtt_host.sv
// host software model driving the indexed register port
`timescale 1ns/10ps
module crtt_host (
    input wire logic clk,
    input wire logic [7:0] io_rdata,
    output logic io_sel,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    initial begin
        io_sel = 1'b0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    task automatic put(input logic sel, input logic [7:0] val);
        @(posedge clk);
        #1;
        io_sel = sel;
        io_wr = 1'b1;
        io_wdata = val;
        @(posedge clk);
        #1;
        io_wr = 1'b0;
        // released data lines show the inverse, not the last value
        io_wdata = ~val;
    endtask
    task automatic get(input logic sel, output logic [7:0] val);
        @(posedge clk);
        #1;
        io_sel = sel;
        io_rd = 1'b1;
        @(posedge clk);
        #1;
        io_rd = 1'b0;
        @(posedge clk);
        #1;
        val = io_rdata;
    endtask
    task automatic wr_reg(input logic [4:0] idx, input logic [7:0] val);
        put(1'b0, {3'h0, idx});
        put(1'b1, idx == 5'h03 ? val | 8'h80 : val);
    endtask
    task automatic rd_reg(input logic [4:0] idx, output logic [7:0] val);
        put(1'b0, {3'h0, idx});
        get(1'b1, val);
    endtask
endmodule

//--- testbench/crtt_timing_tb.sv
// self-checking bench for the crt timing register block
`timescale 1ns/10ps
module crtt_timing_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic io_sel, io_wr, io_rd;
    logic [7:0] io_wdata, io_rdata, v, eb, hs;
    logic char_tick = 1'b1;
    logic [7:0] hcount = 8'h00;
    logic [7:0] hblank_begin = 8'd36;
    logic display_enable_raw = 1'b0;
    logic vretrace = 1'b0;
    logic ext_graphics = 1'b0;
    logic [4:0] cursor_last_line = 5'h03;
    logic [15:0] start_addr = 16'h0000;
    logic display_enable, hblank, hsync, cursor_row;
    logic [4:0] row_scan, r;
    logic [1:0] byte_pan;
    logic [15:0] start_addr_latched;
    logic [9:0] frame_lines, vsync_start_hi, vactive_end_hi;
    logic [9:0] split_line_hi, vblank_start_hi;
    logic [7:0] cfg [3] = '{8'h01, 8'h21, 8'h04};
    int error_cnt = 0;
    int cmp_count = 0;
    int n, base, chg;
    always #25 clk = ~clk;
    // stands in for the horizontal character counter, 50 per line
    always @(posedge clk) begin
        #1;
        hcount <= hcount == 8'd49 ? 8'h00 : hcount + 8'h01;
        display_enable_raw <= hcount == 8'd49 || hcount < 8'd31;
    end
    crtt_timing u_dut (.clk, .rst_b, .io_sel, .io_wr, .io_rd, .io_wdata,
        .io_rdata, .char_tick, .hcount, .hblank_begin, .display_enable_raw,
        .vretrace, .ext_graphics, .cursor_last_line, .start_addr,
        .display_enable, .hblank, .hsync, .row_scan, .cursor_row, .byte_pan,
        .start_addr_latched, .frame_lines, .vsync_start_hi, .vactive_end_hi,
        .split_line_hi, .vblank_start_hi);
    crtt_host u_host (.clk, .io_rdata, .io_sel, .io_wr, .io_rd, .io_wdata);
    task automatic complete_run;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic sig(input int w, input logic [7:0] c);
        case (w)
            0: return hcount == c;
            1: return hsync;
            2: return display_enable;
            3: return !hsync;
            4: return hblank;
            default: return !hblank;
        endcase
    endfunction
    // counts clock edges until the chosen condition holds mid-cycle
    task automatic step(input int w, input logic [7:0] c, output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (sig(w, c) !== 1'b1 && k < 300);
        if (k >= 300) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic vpulse(input logic [15:0] a);
        step(0, 8'd30, n);
        @(posedge clk);
        #1;
        vretrace = 1'b1;
        start_addr = a;
        repeat (4) @(posedge clk);
        #1;
        vretrace = 1'b0;
        start_addr = ~a;
        @(negedge clk);
        check("start addr", start_addr_latched, a);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        for (int i = 3; i <= 11; i++) begin
            u_host.rd_reg(i[4:0], v);
            check("reset", v, i == 3 ? 8'h80 : 8'h00);
            u_host.wr_reg(i[4:0], 8'hff);
            u_host.rd_reg(i[4:0], v);
            check("readback", v, i == 8 ? 8'h7f : i == 10 ? 8'h3f :
                i == 11 ? 8'h00 : 8'hff);
        end
        u_host.get(1'b0, v);
        check("index", v, 8'h0b);
        eb = 8'd36 + 8'd8;
        hs = 8'd10 + 8'd4;
        u_host.wr_reg(5'h04, 8'd10);
        for (int d = 0; d < 4; d++) begin
            u_host.wr_reg(5'h05, {eb[5], d[1:0], hs[4:0]});
            u_host.wr_reg(5'h03, {1'b1, d[1:0], eb[4:0]});
            step(0, 8'd10, n);
            step(1, 8'd0, n);
            check("sync delay", n, 2 + d);
            step(3, 8'd0, n);
            check("sync width", n, 4);
            step(0, 8'd0, n);
            step(2, 8'd0, n);
            if (d == 0) base = n;
            check("enable skew", n, base + d);
            step(0, 8'd36, n);
            step(4, 8'd0, n);
            check("blank start", n, 2);
            step(5, 8'd0, n);
            check("blank width", n, 8);
        end
        u_host.wr_reg(5'h08, 8'h42);
        repeat (2) @(negedge clk);
        check("pan", byte_pan, 2'h2);
        ext_graphics = 1'b1;
        @(negedge clk);
        @(negedge clk);
        check("pan ext", byte_pan, 2'h0);
        ext_graphics = 1'b0;
        u_host.wr_reg(5'h08, 8'h02);
        u_host.wr_reg(5'h09, 8'h44);
        u_host.wr_reg(5'h06, 8'h5a);
        u_host.wr_reg(5'h07, 8'ha5);
        // outputs are registered one edge after the register itself
        repeat (2) @(negedge clk);
        check("frame", frame_lines, 10'h35a);
        check("vsync hi", vsync_start_hi, 10'h300);
        check("vactive hi", vactive_end_hi, 10'h000);
        check("split hi", split_line_hi, 10'h200);
        check("vblank hi", vblank_start_hi, 10'h000);
        foreach (cfg[c]) begin
            u_host.wr_reg(5'h0a, cfg[c]);
            vpulse(16'h1234 + 16'(c));
            for (int k = 0; k < 5; k++) begin
                r = k == 0 ? 5'h02 : (r >= 5'h04 ? 5'h00 : r + 5'h01);
                step(1, 8'd0, n);
                step(3, 8'd0, n);
                repeat (3) @(negedge clk);
                check("row", row_scan, r);
                check("cursor", cursor_row, !cfg[c][5] &&
                    cfg[c][4:0] <= 5'h03 && r >= cfg[c][4:0] && r <= 5'h03);
            end
        end
        u_host.wr_reg(5'h09, 8'hc4);
        vpulse(16'h00aa);
        chg = 0;
        step(1, 8'd0, n);
        step(3, 8'd0, n);
        // let the preset reload land before taking the first sample
        repeat (3) @(negedge clk);
        for (int k = 0; k < 8; k++) begin
            r = row_scan;
            step(1, 8'd0, n);
            step(3, 8'd0, n);
            repeat (3) @(negedge clk);
            if (row_scan !== r) chg++;
        end
        check("double scan", chg, 4);
        complete_run();
    end
endmodule
bind crtt_timing crtt_timing_assertions #(.CNT_W(CNT_W), .VPOS_W(VPOS_W))
    u_chk (.clk, .rst_b, .io_sel, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .char_tick, .hcount, .ext_graphics, .vretrace, .start_addr,
    .start_addr_latched, .hsync, .row_scan, .cursor_row, .byte_pan,
    .frame_lines, .vsync_start_hi, .vactive_end_hi, .split_line_hi,
    .vblank_start_hi);
